/* rtl/hpl_pkg.sv */
// package: register map and carriers for the host port paging block
package hpl_pkg;
	// ==========================================================
	// register offsets (full internal byte addresses)
	localparam logic [14:0] HPL_OFS_LOCK_DELAY = 15'h0638;
	localparam logic [14:0] HPL_OFS_PORT_CTRL = 15'h067E;
	localparam logic [14:0] HPL_OFS_PAGE_SEL = 15'h067F;
	// in-page offsets of the two port registers, mirrored on every page
	localparam logic [6:0] HPL_LOW_PORT_CTRL = 7'h7E;
	localparam logic [6:0] HPL_LOW_PAGE_SEL = 7'h7F;
	// ==========================================================
	// reset values
	localparam logic [7:0] HPL_RST_LOCK_DELAY = 8'h00;
	localparam logic [7:0] HPL_RST_PORT_CTRL = 8'h00;
	localparam logic [7:0] HPL_RST_PAGE_SEL = 8'h00;
	// ==========================================================
	// field positions of the port control register
	localparam int HPL_BIT_LOCKOUT = 7;
	localparam int HPL_BIT_STATUS = 0;
	// ==========================================================
	// paging
	localparam int HPL_PAGE_W = 8;
	localparam int HPL_LOW_W = 7;
	localparam int HPL_ADDR_W = 15;
	localparam logic [7:0] HPL_PAGE_MAX = 8'h0D;
	localparam logic [7:0] HPL_PAGE_RSV_A = 8'h07;
	localparam logic [7:0] HPL_PAGE_RSV_B = 8'h09;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] wdata;
	} hpl_req_t;

	typedef struct packed {
		logic we;
		logic [14:0] addr;
		logic [7:0] wdata;
	} hpl_ext_t;
endpackage : hpl_pkg

/* rtl/hpl_page_xlat.sv */
// module: page plus in-page offset to internal address, page check
`timescale 1ns/1ns
`default_nettype none
module hpl_page_xlat
	import hpl_pkg::*;
#(
	parameter int PAGE_W = 8,
	parameter int LOW_W = 7
) (
	// page and offset in
	input wire logic [PAGE_W-1:0] page,
	input wire logic [LOW_W-1:0] low_addr,
	// translated address out
	output logic [PAGE_W+LOW_W-1:0] full_addr,
	output logic page_ok
);
	// ==========================================================
	// address forming
	assign full_addr = {page, low_addr}; // [RULE8]
	// valid pages 0..6, 8, 10..13
	assign page_ok = (page <= PAGE_W'(HPL_PAGE_MAX))
		&& (page != PAGE_W'(HPL_PAGE_RSV_A))
		&& (page != PAGE_W'(HPL_PAGE_RSV_B)); // [RULE5]
endmodule : hpl_page_xlat
`default_nettype wire

/* rtl/hpl_host_port.sv */
// module: host port paging, write lockout, access status, lock delay
//
// Overview of operation
// RULE1 - while lockout is set, writes to every other port register are ignored
// RULE2 - with lockout clear, host writes to all registers are accepted
// RULE3 - status bit 0 of port control is set when an access fails
// RULE4 - a successful access clears status so the register reads back zero; with lockout set the register reads back 0x80
// RULE5 - page select value N picks the N-th 128-byte page; 0-6, 8, 10-13
// RULE6 - host must not program page codes 7, 9 or above 13
// RULE7 - an 8-bit host-writable lock declaration delay is held for the DPLLs
// RULE8 - internal address is page times 128 plus seven low address bits
`timescale 1ns/1ns
`default_nettype none
module hpl_host_port
	import hpl_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// host access request
	input wire logic HOST_REQ,
	input wire hpl_req_t HOST_REQ_DATA,
	output logic HOST_BUSY,
	// host access answer
	output logic HOST_ACK,
	output logic HOST_ERR,
	output logic [7:0] HOST_RDATA,
	// other device registers
	output logic EXT_RD_STB,
	output logic EXT_WR_STB,
	output hpl_ext_t EXT_REQ_DATA,
	input wire logic EXT_HIT,
	input wire logic [7:0] EXT_RDATA,
	// control outputs
	output logic [7:0] PAGE_SEL,
	output logic LOCKOUT,
	output logic [7:0] LOCK_DELAY
);
	// ==========================================================
	// state
	typedef enum logic [0:0] {
		HPL_IDLE = 1'b0,
		HPL_EXEC = 1'b1
	} hpl_state_t;

	hpl_state_t state_r, state_nxt;
	hpl_req_t req_r;
	logic lockout_r;
	logic status_r;
	logic [7:0] page_r;
	logic [7:0] delay_r;
	logic busy_r;
	logic ack_r;
	logic err_r;
	logic [7:0] rdata_r;
	logic ext_rd_r;
	logic ext_wr_r;
	hpl_ext_t ext_r;

	// ==========================================================
	// address decode
	wire logic [14:0] full_addr;
	wire logic page_ok;

	hpl_page_xlat #(
		.PAGE_W(HPL_PAGE_W),
		.LOW_W(HPL_LOW_W)
	) u_xlat (
		.page(page_r),
		.low_addr(req_r.addr),
		.full_addr(full_addr),
		.page_ok(page_ok)
	);

	wire logic take = HOST_REQ && (state_r == HPL_IDLE);
	wire logic exec = (state_r == HPL_EXEC);
	wire logic hit_ctrl = (req_r.addr == HPL_LOW_PORT_CTRL);
	wire logic hit_page = (req_r.addr == HPL_LOW_PAGE_SEL);
	wire logic hit_delay = page_ok && (full_addr == HPL_OFS_LOCK_DELAY);
	wire logic hit_own = hit_ctrl || hit_page || hit_delay;
	// outside access only on a valid page and not one of our registers
	wire logic hit_ext = page_ok && !hit_own && EXT_HIT;
	wire logic mapped = hit_own || hit_ext;
	// control register itself stays writable so lockout can be cleared
	wire logic wr_blocked = req_r.we && lockout_r && !hit_ctrl; // [RULE1]
	wire logic wr_ok = exec && req_r.we && mapped && !wr_blocked; // [RULE2]
	wire logic acc_fail = !mapped || wr_blocked;
	wire logic [7:0] ctrl_val = {lockout_r, 6'h00, status_r};
	wire logic [7:0] own_rdata = hit_ctrl ? ctrl_val
		: hit_page ? page_r
		: hit_delay ? delay_r
		: EXT_RDATA;

	// ==========================================================
	// next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			HPL_IDLE: begin
				if (HOST_REQ) begin
					state_nxt = HPL_EXEC;
				end
			end
			HPL_EXEC: begin
				state_nxt = HPL_IDLE;
			end
		endcase
	end

	// ==========================================================
	// answer next values
	// writes and failed accesses answer zero
	wire logic answer_zero = req_r.we || acc_fail;
	wire logic [7:0] rdata_nxt = answer_zero ? 8'h00 : own_rdata;
	wire logic err_nxt = exec && acc_fail; // [RULE3]

	// ==========================================================
	// sequencing
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_r <= HPL_IDLE;
			req_r <= '0;
			busy_r <= 1'b0;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (take) begin
				req_r <= HOST_REQ_DATA;
			end
			busy_r <= take;
			ack_r <= exec;
			err_r <= err_nxt; // [RULE3]
			if (exec) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ==========================================================
	// outside register strobes, two cycles after the request, with the answer
	wire logic ext_go = exec && hit_ext;
	wire logic ext_rd_nxt = ext_go && !req_r.we;
	wire logic ext_wr_nxt = ext_go && req_r.we && !wr_blocked; // [RULE1]
	hpl_ext_t ext_nxt;

	assign ext_nxt = '{we: req_r.we, addr: full_addr, wdata: req_r.wdata};

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ext_rd_r <= 1'b0;
			ext_wr_r <= 1'b0;
			ext_r <= '0;
		end else begin
			ext_rd_r <= ext_rd_nxt;
			ext_wr_r <= ext_wr_nxt; // [RULE1]
			if (ext_go) begin
				ext_r <= ext_nxt;
			end
		end
	end

	// ==========================================================
	// own registers
	wire logic wr_ctrl = wr_ok && hit_ctrl;
	wire logic wr_page = wr_ok && hit_page;
	wire logic wr_delay = wr_ok && hit_delay;
	// only lockout is writable; status follows each access
	wire logic lockout_nxt = wr_ctrl ? req_r.wdata[HPL_BIT_LOCKOUT]
		: lockout_r; // [RULE2]
	// failure sets, success clears
	wire logic status_nxt = exec ? acc_fail : status_r; // [RULE3] [RULE4]
	wire logic [7:0] page_nxt = wr_page ? req_r.wdata : page_r; // [RULE5]
	wire logic [7:0] delay_nxt = wr_delay ? req_r.wdata : delay_r; // [RULE7]

	// ==========================================================
	// port control register
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			lockout_r <= HPL_RST_PORT_CTRL[HPL_BIT_LOCKOUT];
			status_r <= HPL_RST_PORT_CTRL[HPL_BIT_STATUS];
		end else begin
			lockout_r <= lockout_nxt; // [RULE2]
			status_r <= status_nxt; // [RULE3] [RULE4]
		end
	end

	// ==========================================================
	// page select register
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			page_r <= HPL_RST_PAGE_SEL;
		end else begin
			page_r <= page_nxt; // [RULE5]
		end
	end

	// ==========================================================
	// lock declaration delay register
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			delay_r <= HPL_RST_LOCK_DELAY;
		end else begin
			delay_r <= delay_nxt; // [RULE7]
		end
	end

	// ==========================================================
	// outputs
	assign HOST_BUSY = busy_r;
	assign HOST_ACK = ack_r;
	assign HOST_ERR = err_r;
	assign HOST_RDATA = rdata_r;
	assign EXT_RD_STB = ext_rd_r;
	assign EXT_WR_STB = ext_wr_r;
	assign EXT_REQ_DATA = ext_r;
	assign PAGE_SEL = page_r;
	assign LOCKOUT = lockout_r;
	assign LOCK_DELAY = delay_r;
endmodule : hpl_host_port
`default_nettype wire

/* tb/hpl_ext_model.sv */
// outside register model
`timescale 1ns/1ns
`default_nettype none
module hpl_ext_model
	import hpl_pkg::*;
(
	input wire logic clk,
	input wire logic req,
	input wire logic busy,
	input wire hpl_req_t rq,
	input wire logic [7:0] page,
	output logic hit,
	output logic [7:0] rdata
);
	logic [14:0] ad = '0;
	always_ff @(posedge clk) if (req && !busy) ad <= {page, rq.addr};
	assign hit = ad[6:4] == 3'b001;
	assign rdata = ad[7:0] ^ 8'hA5;
endmodule : hpl_ext_model
`default_nettype wire

/* tb/hpl_host_port_assertions.sv */
// checker for the host port block
`timescale 1ns/1ns
`default_nettype none
module hpl_chk
	import hpl_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic HOST_REQ,
	input wire hpl_req_t HOST_REQ_DATA,
	input wire logic HOST_BUSY,
	input wire logic HOST_ACK,
	input wire logic HOST_ERR,
	input wire logic [7:0] HOST_RDATA,
	input wire logic EXT_WR_STB,
	input wire hpl_ext_t EXT_REQ_DATA,
	input wire logic EXT_HIT,
	input wire logic [7:0] PAGE_SEL,
	input wire logic LOCKOUT,
	input wire logic [7:0] LOCK_DELAY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	wire tk = HOST_REQ && !HOST_BUSY;
	wire wr = tk && HOST_REQ_DATA.we;
	wire [6:0] a = HOST_REQ_DATA.addr;
	wire [7:0] d = HOST_REQ_DATA.wdata;
	property p_lk;
		wr && LOCKOUT && a != 7'h7E |-> ##2 HOST_ERR && !EXT_WR_STB;
	endproperty
	a_lk: assert property (p_lk) else $error("locked write");
	property p_op;
		wr && !LOCKOUT && a == 7'h7F |-> ##2 PAGE_SEL == $past(d, 2);
	endproperty
	a_op: assert property (p_op) else $error("page write");
	property p_fl;
		HOST_BUSY && !EXT_HIT && $past(a) < 7'h38 |=> HOST_ERR;
	endproperty
	a_fl: assert property (p_fl) else $error("no fail");
	// error of the last answered access, shown in the status bit
	logic last_err;
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			last_err <= 1'b0;
		end else if (HOST_ACK) begin
			last_err <= HOST_ERR;
		end
	end
	property p_rb;
		tk && !wr && a == 7'h7E
			|-> ##2 HOST_RDATA == {LOCKOUT, 6'h00, last_err};
	endproperty
	a_rb: assert property (p_rb) else $error("ctrl read");
	property p_pg;
		EXT_WR_STB |-> $past(PAGE_SEL, 2) <= 8'h0D
			&& $past(PAGE_SEL, 2) != 8'h07 && $past(PAGE_SEL, 2) != 8'h09;
	endproperty
	a_pg: assert property (p_pg) else $error("bad page");
	property p_dl;
		wr && !LOCKOUT && PAGE_SEL == 8'h0C && a == 7'h38
			|-> ##2 LOCK_DELAY == $past(d, 2);
	endproperty
	a_dl: assert property (p_dl) else $error("delay");
	property p_ad;
		EXT_WR_STB |-> EXT_REQ_DATA.addr == {$past(PAGE_SEL, 2), $past(a, 2)};
	endproperty
	a_ad: assert property (p_ad) else $error("address");
endmodule : hpl_chk
bind hpl_host_port hpl_chk chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
	.HOST_REQ(HOST_REQ), .HOST_REQ_DATA(HOST_REQ_DATA),
	.HOST_BUSY(HOST_BUSY), .HOST_ACK(HOST_ACK),
	.HOST_ERR(HOST_ERR), .HOST_RDATA(HOST_RDATA),
	.EXT_WR_STB(EXT_WR_STB), .EXT_REQ_DATA(EXT_REQ_DATA), .EXT_HIT(EXT_HIT),
	.PAGE_SEL(PAGE_SEL), .LOCKOUT(LOCKOUT), .LOCK_DELAY(LOCK_DELAY));
`default_nettype wire

/* tb/tb_hpl_host_port.sv */
// testbench for the host port block
`timescale 1ns/1ns
`default_nettype none
module tb_hpl_host_port;
	import hpl_pkg::*;
	logic clk = 0, rst = 1, req = 0, busy, ack, err, rs, ws, hit, lk;
	logic rs_seen = 0, ws_seen = 0;
	logic [7:0] rd, xd, pg, dl;
	hpl_req_t rq = '0;
	hpl_ext_t xq;
	int mismatches = 0, compares = 0;
	always #2 clk = ~clk;
	hpl_host_port uut (.CORE_CLK(clk), .RESET(rst), .HOST_REQ(req),
		.HOST_REQ_DATA(rq), .HOST_BUSY(busy), .HOST_ACK(ack), .HOST_ERR(err),
		.HOST_RDATA(rd), .EXT_RD_STB(rs), .EXT_WR_STB(ws), .EXT_REQ_DATA(xq),
		.EXT_HIT(hit), .EXT_RDATA(xd), .PAGE_SEL(pg), .LOCKOUT(lk),
		.LOCK_DELAY(dl));
	hpl_ext_model ext (.clk(clk), .req(req), .busy(busy), .rq(rq),
		.page(pg), .hit(hit), .rdata(xd));
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(string n, logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic acc(logic w, logic [6:0] a, logic [7:0] d, logic e,
		logic [7:0] r);
		int i;
		logic bz;
		@(posedge clk) #1;
		req = 1;
		rq = '{w, a, d};
		@(posedge clk) #1;
		req = 0;
		bz = busy;
		for (i = 0; i < 4 && ack !== 1'b1; i++) @(posedge clk) #1;
		rs_seen = rs;
		ws_seen = ws;
		if (ack !== 1'b1) begin
			mismatches++;
			final_report();
		end else begin
			chk("answer", {5'h00, bz, i == 1, err, rd}, {5'h00, 2'h3, e, r});
		end
	endtask : acc
	task automatic t_page();
		chk("reset", {pg, dl}, 16'h0000);
		acc(1'b1, 7'h7F, 8'h0C, 1'b0, 8'h00);
		chk("page", {8'h0, pg}, 16'h000C);
		acc(1'b1, 7'h38, 8'h5A, 1'b0, 8'h00);
		chk("delay", {8'h0, dl}, 16'h005A);
		acc(1'b0, 7'h38, 8'h00, 1'b0, 8'h5A);
		acc(1'b0, 7'h12, 8'h00, 1'b0, 8'hB7);
		chk("rd strobe", {14'h0, rs_seen, ws_seen}, 16'h0002);
		acc(1'b0, 7'h05, 8'h00, 1'b1, 8'h00);
		acc(1'b0, 7'h7E, 8'h00, 1'b0, 8'h01);
		acc(1'b0, 7'h7E, 8'h00, 1'b0, 8'h00);
		$display("page test done");
	endtask : t_page
	task automatic t_lock();
		acc(1'b1, 7'h7E, 8'h80, 1'b0, 8'h00);
		chk("lockout", {15'h0, lk}, 16'h0001);
		acc(1'b1, 7'h7F, 8'h03, 1'b1, 8'h00);
		acc(1'b1, 7'h38, 8'h11, 1'b1, 8'h00);
		acc(1'b1, 7'h12, 8'h66, 1'b1, 8'h00);
		chk("locked strobe", {14'h0, rs_seen, ws_seen}, 16'h0000);
		chk("locked", {pg, dl}, 16'h0C5A);
		acc(1'b0, 7'h7E, 8'h00, 1'b0, 8'h81);
		acc(1'b1, 7'h7E, 8'h00, 1'b0, 8'h00);
		chk("unlocked", {15'h0, lk}, 16'h0000);
		acc(1'b1, 7'h7F, 8'h03, 1'b0, 8'h00);
		acc(1'b1, 7'h12, 8'h44, 1'b0, 8'h00);
		chk("wr strobe", {14'h0, rs_seen, ws_seen}, 16'h0001);
		chk("ext addr", {1'b0, xq.addr}, 16'h0192);
		chk("ext data", {7'h0, xq.we, xq.wdata}, 16'h0144);
		acc(1'b0, 7'h12, 8'h00, 1'b0, 8'h37);
		$display("lock test done");
	endtask : t_lock
	task automatic t_refuse();
		@(posedge clk) #1;
		req = 1;
		rq = '{1'b1, 7'h7F, 8'h0C};
		@(posedge clk) #1;
		rq = '{1'b1, 7'h7F, 8'h05};
		@(posedge clk) #1;
		req = 0;
		chk("first ack", {15'h0, ack}, 16'h0001);
		@(posedge clk) #1;
		chk("second ack", {15'h0, ack}, 16'h0000);
		chk("one write", {8'h00, pg}, 16'h000C);
		$display("refuse test done");
	endtask : t_refuse
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 0;
		t_page();
		t_lock();
		t_refuse();
		final_report();
	end
endmodule : tb_hpl_host_port
`default_nettype wire
